/* File: dea_pkg.sv */
// Package: register map, field positions and timing constants
package dea_pkg;
	// Register byte addresses on the AHB-Lite bus
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_UNLOCK  = 8'h04;
	localparam logic [7:0] ADDR_INDEX   = 8'h08;
	localparam logic [7:0] ADDR_VALUE   = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
	// Control register fields
	localparam int BIT_PGM   = 7;
	localparam int BIT_CFG   = 6;
	localparam int BIT_ABORT = 3;
	localparam int BIT_WPERM = 2;
	localparam int BIT_WR    = 1;
	localparam int BIT_RD    = 0;
	// Flag register field
	localparam int BIT_DONE  = 4;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	// Write cycle timing
	localparam int CLK_HZ        = 20_000_000;
	localparam int WRITE_TIME_US = 4000;
	localparam int WRITE_CYCLES  = WRITE_TIME_US * (CLK_HZ / 1_000_000);
	// Unlock sequence states
	typedef enum logic [1:0] {UNL_IDLE, UNL_ONE, UNL_ARMED} dea_unl_t;
endpackage

/* File: dea_ctrl.sv */
// Data EEPROM access control with AHB-Lite register port
// Summary of operation
// [R01] Program-space select 0 targets data array, 1 targets program memory.
// [R02] Config-space select set targets configuration registers instead.
// [R03] Writes only while write-permit set; write-permit clear after reset.
// [R04] Abort flag set on reset mid-write or improper attempt, clear on done; here reset clears it.
// [R05] Software can set write-start only; hardware clears it at cycle end.
// [R06] Write completion sets sticky done flag at bit 4, software clears.
// [R07] Read-start and write-start self-clear when their operation ends.
// [R08] Read-start ignored while program-space select is 1.
// [R09] Unlock port stores nothing and reads as zero.
// [R10] Firmware loads index, clears program select, then sets read-start.
// [R11] Read byte lands in value register before next access; a back-to-back value read here returns the old byte.
// [R12] Value register holds read byte until next read or software write.
// [R13] Write starts only after keys 55h, AAh then write-start, per byte.
// [R14] Write-start refused unless write-permit was already set.
// [R15] Control, index and value registers frozen during a write cycle; value reloads here if read-start came with write-start.
// [R16] Data array holds 256 bytes indexed 00h to FFh.
// [R17] Write cycle timed by parameter counter; expiry clears start, sets done.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module dea_ctrl
	import dea_pkg::*;
#(
	parameter int WRITE_CYCLES_P = dea_pkg::WRITE_CYCLES,
	parameter int DEPTH          = 256
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Target selection seen by the memory system
	output logic             sel_data,
	output logic             sel_program,
	output logic             sel_config,
	// Interrupt
	output logic             irq
);
	import dea_pkg::*;

	// Data array; DEPTH bytes, index width fixed at 8 bits
	logic [7:0] mem [DEPTH];

	// Bus address phase capture
	logic       ph_wr, ph_rd, next_ph_wr, next_ph_rd;
	logic [7:0] ph_addr, next_ph_addr;

	// Register state
	logic [7:0]  ctl, next_ctl;
	logic [7:0]  idx, next_idx;
	logic [7:0]  val, next_val;
	logic        done, next_done;
	logic        irq_en, next_irq_en;
	logic        wperm_old, next_wperm_old;
	logic [31:0] cnt, next_cnt;
	logic [31:0] next_hrdata;
	dea_unl_t    unl, next_unl;

	// Decoded data-phase strobes and write cycle events
	logic [7:0]  wd;
	logic        wr_ctl, wr_unl, wr_idx, wr_val, wr_ien, wr_clr;
	logic        start_ok, wr_go, wr_end, mem_we;

	// Write cycle in flight; control writes are refused while it stands
	wire busy = ctl[BIT_WR];

	// Single-cycle slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Memory target decode; config select overrides program select
	assign sel_config  = ctl[BIT_CFG];                   // R02
	assign sel_program = ~ctl[BIT_CFG] & ctl[BIT_PGM];   // R01
	assign sel_data    = ~ctl[BIT_CFG] & ~ctl[BIT_PGM];  // R01
	// Level interrupt: sticky done flag gated by its enable
	assign irq         = done & irq_en;

	// Byte register placed in the low lane of a read word
	function automatic logic [31:0] byte_word(input logic [7:0] b);
		return {24'h00_0000, b};
	endfunction

	// Single flag placed at the done-bit position of a read word
	// Shared by the flag and enable registers, which have one layout
	function automatic logic [31:0] flag_word(input logic f);
		logic [31:0] w;
		w           = 32'h0000_0000;
		w[BIT_DONE] = f;
		return w;
	endfunction

	// Data-phase write strobes; each register write lands at the end of it
	assign wd     = hwdata[7:0];
	assign wr_ctl = ph_wr && (ph_addr == ADDR_CONTROL);
	assign wr_unl = ph_wr && (ph_addr == ADDR_UNLOCK);
	assign wr_idx = ph_wr && (ph_addr == ADDR_INDEX);
	assign wr_val = ph_wr && (ph_addr == ADDR_VALUE);
	assign wr_ien = ph_wr && (ph_addr == ADDR_IRQ_EN);
	assign wr_clr = ph_wr && (ph_addr == ADDR_IRQ_CLR);

	// Write cycle ends on the last count of the timer
	assign wr_end   = busy && (cnt == 32'd1); // R17
	// Start needs the armed keys and a permit that stood before this write,
	// so one write cannot raise permit and start together
	assign start_ok = (unl == UNL_ARMED) && wperm_old
		&& ctl[BIT_WPERM] && wd[BIT_WPERM]; // R13 R14
	assign wr_go    = wr_ctl && !busy && wd[BIT_WR] && start_ok; // R03
	// Array is written only when the data array is the target
	assign mem_we   = wr_end && sel_data; // R01

	// Address phase capture: the register write waits for the data phase
	always_comb begin
		next_ph_wr   = hsel & htrans[1] & hready & hwrite;
		next_ph_rd   = hsel & htrans[1] & hready & ~hwrite;
		next_ph_addr = haddr[7:0];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_wr   <= 1'b0;
			ph_rd   <= 1'b0;
			ph_addr <= 8'h00;
		end else begin
			ph_wr   <= next_ph_wr;
			ph_rd   <= next_ph_rd;
			ph_addr <= next_ph_addr;
		end
	end

	// Write cycle timer; a reload only happens while idle, so no clash
	// Thirty-two bits cover millisecond write times at the core clock
	always_comb begin
		next_cnt = cnt;
		if (busy)
			next_cnt = cnt - 32'd1; // R17
		if (wr_go)
			next_cnt = 32'(WRITE_CYCLES_P); // R17
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 32'h0000_0000;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Control register; read is instantaneous, so its bit drops next cycle
	// A refused start still raises the abort flag so software can see it
	always_comb begin
		next_ctl       = ctl;
		next_wperm_old = ctl[BIT_WPERM]; // R14
		if (ctl[BIT_RD])
			next_ctl[BIT_RD] = 1'b0; // R07
		if (wr_end) begin
			next_ctl[BIT_WR]    = 1'b0; // R05
			next_ctl[BIT_ABORT] = 1'b0; // R04
		end
		if (wr_ctl && !busy) begin // R15
			next_ctl[BIT_PGM]   = wd[BIT_PGM];
			next_ctl[BIT_CFG]   = wd[BIT_CFG];
			next_ctl[BIT_WPERM] = wd[BIT_WPERM];
			if (!wd[BIT_ABORT])
				next_ctl[BIT_ABORT] = 1'b0;
			if (wd[BIT_RD] && !wd[BIT_PGM])
				next_ctl[BIT_RD] = 1'b1; // R08
			if (wd[BIT_WR]) begin
				next_ctl[BIT_ABORT] = 1'b1; // R04
				if (wr_go)
					next_ctl[BIT_WR] = 1'b1; // R13 R14
			end
		end
	end

	// Abort flag is set while a write is in flight, so a reset there leaves it
	// at one; it powers up cleared here since no retention is modelled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctl       <= RST_CONTROL; // R03
			wperm_old <= 1'b0;
		end else begin
			ctl       <= next_ctl;
			wperm_old <= next_wperm_old;
		end
	end

	// Unlock key tracker; the port itself stores nothing
	// Any other register write in between drops the sequence
	always_comb begin
		next_unl = unl;
		if (ph_wr && !wr_unl)
			next_unl = UNL_IDLE; // R13
		if (wr_unl) begin
			case (unl)
			UNL_ONE: begin
				if (wd == KEY_SECOND)
					next_unl = UNL_ARMED; // R13
				else if (wd == KEY_FIRST)
					next_unl = UNL_ONE;
				else
					next_unl = UNL_IDLE;
			end
			default: begin
				if (wd == KEY_FIRST)
					next_unl = UNL_ONE; // R09 R13
				else
					next_unl = UNL_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unl <= UNL_IDLE;
		end else begin
			unl <= next_unl;
		end
	end

	// Index and value registers; bus writes to them are ignored while a write cycle runs
	// A bus write to value in the same cycle as a read wins
	always_comb begin
		next_idx = idx;
		next_val = val;
		if (ctl[BIT_RD] && sel_data)
			next_val = mem[idx]; // R11 R16
		if (wr_idx && !busy)
			next_idx = wd; // R15
		if (wr_val && !busy)
			next_val = wd; // R12 R15
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idx <= 8'h00;
			val <= 8'h00;
		end else begin
			idx <= next_idx;
			val <= next_val;
		end
	end

	// Interrupt flags; completion wins over a clear in the same cycle,
	// so software never loses an event that it did not see
	always_comb begin
		next_done   = done;
		next_irq_en = irq_en;
		if (wr_ien)
			next_irq_en = wd[BIT_DONE];
		if (wr_clr && wd[BIT_DONE])
			next_done = 1'b0; // R06
		if (wr_end)
			next_done = 1'b1; // R06 R17
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			done   <= 1'b0;
			irq_en <= 1'b0;
		end else begin
			done   <= next_done;
			irq_en <= next_irq_en;
		end
	end

	// Read data from next values, so a read right behind a write sees it
	// Cost: the read mux sits behind the register next-state logic
	always_comb begin
		next_hrdata = 32'h0000_0000;
		if (next_ph_rd) begin
			case (next_ph_addr)
			ADDR_CONTROL: next_hrdata = byte_word(next_ctl & 8'hCF);
			ADDR_UNLOCK:  next_hrdata = 32'h0000_0000; // R09
			ADDR_INDEX:   next_hrdata = byte_word(next_idx);
			ADDR_VALUE:   next_hrdata = byte_word(next_val); // R11
			ADDR_FLAGS:   next_hrdata = flag_word(next_done); // R06
			ADDR_IRQ_EN:  next_hrdata = flag_word(next_irq_en);
			default:      next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data stands for the data phase only, zero otherwise
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// Array write at cycle end; no reset so it maps onto storage
	always_ff @(posedge clk) begin
		if (mem_we)
			mem[idx] <= val; // R17
	end
endmodule

/* File: dea_ctrl_assertions.sv */
// Port-level checks for the data EEPROM access control block
`timescale 1ns/1ns
module dea_ctrl_assertions (
	// Clock and reset
	input logic        clk,
	input logic        nrst,
	// Bus
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic [31:0] hrdata,
	// Targets and interrupt
	input logic        sel_data,
	input logic        sel_program,
	input logic        sel_config,
	input logic        irq
);
	import dea_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Accepted address phases
	wire       tk = hsel && htrans[1] && hready;
	wire       wt = tk && hwrite;
	wire       rt = tk && !hwrite;
	wire [7:0] a  = haddr[7:0];
	wire [2:0] s  = {sel_data, sel_program, sel_config};
	sel_onehot_a: assert property (s inside {3'h4, 3'h2, 3'h1})
		else $error("target select not one-hot");
	sel_change_a: assert property (!$stable(s) |->
		$past(wt && a == ADDR_CONTROL, 2)) else $error("select moved alone");
	unlock_zero_a: assert property (rt && a == ADDR_UNLOCK |=>
		hrdata == 32'h0) else $error("unlock port read not zero");
	flag_bits_a: assert property (rt && a == ADDR_FLAGS |=>
		(hrdata & ~32'h10) == 32'h0) else $error("flag bits wrong");
	upper_zero_a: assert property (rt |=> hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	irq_sticky_a: assert property ($fell(irq) |-> $past(wt &&
		(a == ADDR_IRQ_CLR || a == ADDR_IRQ_EN), 2))
		else $error("irq dropped alone");
	rd_clear_a: assert property (rt && a == ADDR_CONTROL &&
		!$past(tk) && !$past(tk, 2) |=> !hrdata[BIT_RD])
		else $error("read start stuck");
	rd_pgm_a: assert property (rt && a == ADDR_CONTROL |=>
		!(hrdata[BIT_RD] && hrdata[BIT_PGM]))
		else $error("read start set with program select");
	// Main scenarios reached
	cover property ($rose(irq));
	cover property (sel_program);
	cover property (rt && a == ADDR_UNLOCK);
endmodule

/* File: data_eeprom_access_control_tb.sv */
// Self-checking bench for the data EEPROM access control block
`timescale 1ns/1ns
module data_eeprom_access_control_tb;
	import dea_pkg::*;
	logic        clk = 0, nrst = 0, hwrite = 0, hsel = 1;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic        hready, hreadyout, hresp;
	logic        sel_data, sel_program, sel_config, irq;
	int          fail_count = 0, checked = 0;
	// One slave: its ready is the bus ready
	assign hready = hreadyout;
	// Short write cycle keeps the run brief
	dea_ctrl #(.WRITE_CYCLES_P(20)) u_dut (.hsize(3'h2), .*);
	initial forever #25 clk = ~clk;
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			fail_count++;
		end
	endtask
	// Single transfer; holds each phase until ready is sampled
	task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		xfer(0, a, 8'h0);
		cmp($sformatf("reg %h", a), {24'h0, e}, r);
	endtask
	// Pins sampled mid-cycle after register updates land
	task automatic pins(logic [3:0] e);
		@(negedge clk);
		@(negedge clk);
		cmp("irq sel", {28'h0, e},
			{28'h0, irq, sel_data, sel_program, sel_config});
	endtask
	task automatic stop_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog well beyond the expected run of under two hundred cycles
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1;
		pins(4'h4);
		rd(ADDR_CONTROL, 8'h00);
		xfer(1, ADDR_UNLOCK, KEY_FIRST);
		rd(ADDR_UNLOCK, 8'h00);
		xfer(1, ADDR_CONTROL, 8'h81);
		rd(ADDR_CONTROL, 8'h80);
		pins(4'h2);
		xfer(1, ADDR_CONTROL, 8'hC0);
		pins(4'h1);
		xfer(1, ADDR_CONTROL, 8'h02);
		rd(ADDR_CONTROL, 8'h08);
		// Keys split by another write must not arm
		xfer(1, ADDR_CONTROL, 8'h04);
		xfer(1, ADDR_UNLOCK, KEY_FIRST);
		xfer(1, ADDR_INDEX, 8'h3C);
		xfer(1, ADDR_UNLOCK, KEY_SECOND);
		xfer(1, ADDR_CONTROL, 8'h06);
		rd(ADDR_CONTROL, 8'h0C);
		xfer(1, ADDR_VALUE, 8'hA5);
		xfer(1, ADDR_UNLOCK, KEY_FIRST);
		xfer(1, ADDR_UNLOCK, KEY_SECOND);
		xfer(1, ADDR_CONTROL, 8'h06);
		rd(ADDR_CONTROL, 8'h0E);
		xfer(1, ADDR_VALUE, 8'h11);
		xfer(1, ADDR_CONTROL, 8'h04);
		rd(ADDR_CONTROL, 8'h0E);
		xfer(1, ADDR_IRQ_EN, 8'h10);
		repeat (25) @(posedge clk);
		rd(ADDR_CONTROL, 8'h04);
		rd(ADDR_FLAGS, 8'h10);
		pins(4'hC);
		rd(ADDR_VALUE, 8'hA5);
		xfer(1, ADDR_VALUE, 8'h00);
		xfer(1, ADDR_CONTROL, 8'h05);
		rd(ADDR_VALUE, 8'hA5);
		rd(ADDR_CONTROL, 8'h04);
		xfer(1, ADDR_VALUE, 8'h5A);
		rd(ADDR_VALUE, 8'h5A);
		xfer(1, ADDR_IRQ_EN, 8'h00);
		pins(4'h4);
		xfer(1, ADDR_IRQ_EN, 8'h10);
		xfer(1, ADDR_IRQ_CLR, 8'h10);
		rd(ADDR_FLAGS, 8'h00);
		pins(4'h4);
		rd(8'h1C, 8'h00);
		stop_test();
	end
endmodule
bind dea_ctrl dea_ctrl_assertions u_chk (.*);
